// File: hdl/psc_pkg.sv
// Overview of operation
// (RULE_01) Keep thirty-two statistics counters for the single Ethernet port.
// (RULE_02) Counter word: bit 31 overflow, bit 30 valid, bits 29:0 count; reset zero.
// (RULE_03) Host rereads the upper data word while its valid flag reads zero.
// (RULE_04) Counters reachable only indirectly, at indirect offsets zero to thirty-one.
// (RULE_05) Counter reads are selected in the indirect control register, bit twelve.
// (RULE_06) Low ten bits of the indirect control register choose the counter.
// (RULE_07) Low data word returns bits 15:0, high data word bits 31:16 with flags.
// (RULE_08) One control write carrying offset, read and table bits triggers the read.
// (RULE_09) Host reads the upper data word first, then the lower word.
// (RULE_10) Reading a counter clears it, so each read returns new events only.
// (RULE_11) Host should read every counter at least once per thirty seconds.
// (RULE_12) Counter 0 adds all received octets; counter 20 good transmitted octets.
// (RULE_13) Software never writes reserved counter offsets one and twenty-one.
// (RULE_14) Offsets 2-5: undersize, fragments, oversize, jabber receive frames.
// (RULE_15) Offsets 6-8: symbol errors, bad-CRC whole-byte, bad-CRC misaligned frames.
// (RULE_16) Offset 9 counts MAC control frames, offset 10 fully qualified pause frames.
// (RULE_17) Offsets 11-13: good broadcast, multicast without control, unicast frames.
// (RULE_18) Offsets 14-19: all received frames in six length bins; the code bins only frames from 64 octets up to the size limit.
// (RULE_19) Offset 22 counts collisions later than 512 bit times into transmit.
// (RULE_20) Offsets 23-26: pause, good broadcast, multicast, unicast transmitted frames.
// (RULE_21) Offsets 27-29: deferred, total collisions, abandoned transmit frames.
// (RULE_22) Offsets 30-31: frames sent after exactly one, or several, collisions.
// (RULE_23) Count wrap sets a sticky overflow flag until the counter is read.
package psc_pkg;
   localparam int          CNT_NUM      = 32;
   localparam int          CNT_W        = 30;
   localparam int          LEN_W        = 14;
   localparam int          ADDR_W       = 16;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTRL     = 16'h04a0;
   localparam logic [15:0] IDX_DLO      = 16'h04a8;
   localparam logic [15:0] IDX_DHI      = 16'h04aa;
   localparam logic [15:0] IDX_CFG      = 16'h04ac;
   localparam logic [15:0] ADDR_CTRL    = {IDX_CTRL[13:0], 2'b00};
   localparam logic [15:0] ADDR_DLO     = {IDX_DLO[13:0], 2'b00};
   localparam logic [15:0] ADDR_DHI     = {IDX_DHI[13:0], 2'b00};
   localparam logic [15:0] ADDR_CFG     = {IDX_CFG[13:0], 2'b00};
   // Indirect control fields
   localparam int          CTRL_OFS_LSB = 0;
   localparam int          CTRL_OFS_MSB = 9;
   localparam int          CTRL_TBL_LSB = 10;
   localparam int          CTRL_TBL_MSB = 11;
   localparam int          CTRL_RD_BIT  = 12;
   localparam logic [1:0]  TBL_STATS    = 2'h3;
   localparam int          CFG_LONG_BIT = 0;
   localparam logic [15:0] CTRL_RST     = 16'h0000;
   localparam logic [15:0] CFG_RST      = 16'h0000;
   // Counter word fields
   localparam int          OVF_BIT      = 31;
   localparam int          VLD_BIT      = 30;
   localparam logic [31:0] SNAP_RST     = 32'h0000_0000;
   // Frame length limits in octets
   localparam logic [13:0] LEN_MIN      = 14'h0040;
   localparam logic [13:0] LEN_B1_MAX   = 14'h007f;
   localparam logic [13:0] LEN_B2_MAX   = 14'h00ff;
   localparam logic [13:0] LEN_B3_MAX   = 14'h01ff;
   localparam logic [13:0] LEN_B4_MAX   = 14'h03ff;
   localparam logic [13:0] LEN_STD_MAX  = 14'h05f2;
   localparam logic [13:0] LEN_LONG_MAX = 14'h0600;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [4:0] {
      C_RX_OCT, C_RSV_1, C_RX_SHORT, C_RX_BROKEN, C_RX_LONG, C_RX_LONG_ERR, C_RX_SYM,
      C_RX_CRC, C_RX_ALIGN, C_RX_CTRL, C_RX_PAUSE, C_RX_BC, C_RX_MC, C_RX_UC,
      C_RX_64, C_RX_127, C_RX_255, C_RX_511, C_RX_1023, C_RX_MAX, C_TX_OCT, C_RSV_21,
      C_TX_LATE, C_TX_PAUSE, C_TX_BC, C_TX_MC, C_TX_UC, C_TX_DEFER, C_TX_COLL,
      C_TX_ABANDON, C_TX_ONE, C_TX_MANY
   } psc_cnt_e_t;

   typedef struct packed {
      logic             done;      // One-cycle pulse at frame end
      logic [13:0]      len;       // Octets in frame
      logic             crc_ok;
      logic             sym_err;
      logic             dribble;   // Non-integral number of bytes
      logic             bcast;
      logic             mcast;     // Group address, not broadcast
      logic             ctrl_type; // Type field 88-08h
      logic             pause_da;
      logic             pause_op;  // Opcode 00-01
   } psc_rx_evt_t;

   typedef struct packed {
      logic             done;      // One-cycle pulse at frame end
      logic [13:0]      len;
      logic             good;
      logic             pause;
      logic             bcast;
      logic             mcast;
      logic             deferred;
      logic [4:0]       coll_cnt;
      logic             abandoned;
      logic             collision; // Pulse per collision, any time
      logic             late_coll; // Pulse per collision past 512 bit times
   } psc_tx_evt_t;
endpackage : psc_pkg

// File: hdl/psc_stats.sv
`timescale 1ns/1ps
module psc_stats (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic [15:0]           s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [15:0]           s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire psc_pkg::psc_rx_evt_t  rx_evt,
   input  wire psc_pkg::psc_tx_evt_t  tx_evt
);

   logic [29:0]  cnt_ff [psc_pkg::CNT_NUM];
   logic [31:0]  ovf_ff;
   logic [13:0]  inc    [psc_pkg::CNT_NUM];
   logic [30:0]  sum    [psc_pkg::CNT_NUM];
   logic [31:0]  clr_vec;

   logic         aw_held_ff;
   logic [15:0]  awaddr_ff;
   logic         w_held_ff;
   logic [31:0]  wdata_ff;
   logic [3:0]   wstrb_ff;
   logic         bvalid_ff;
   logic [1:0]   bresp_ff;
   logic         rvalid_ff;
   logic [31:0]  rdata_ff;
   logic [1:0]   rresp_ff;

   logic [15:0]  ctrl_ff;
   logic [15:0]  cfg_ff;
   logic [31:0]  snap_ff;

   logic         wr_go;
   logic         wr_ctrl;
   logic         wr_cfg;
   logic         wr_hit;
   logic [15:0]  nxt_ctrl;
   logic [15:0]  nxt_cfg;
   logic         trig;
   logic [9:0]   sel;
   logic         sel_ok;
   logic [4:0]   sel_idx;
   logic [31:0]  nxt_rdata;
   logic [1:0]   nxt_rresp;

   logic [13:0]  len_max;
   logic [13:0]  rl;
   logic         r_lo;
   logic         r_mid;
   logic         r_hi;
   logic         r_err;
   logic         r_good;

   // Word-aligned address match
   function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] reg_addr);
      addr_hit = (a[15:2] == reg_addr[15:2]);
   endfunction : addr_hit

   // One event as a counter increment
   function automatic logic [13:0] one(input logic cond);
      one = {13'h0000, cond};
   endfunction : one

   // Apply the two low byte strobes to a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction : merge16

   // Write address and write data are taken independently, in either order
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aw_held_ff <= 1'b0;
         awaddr_ff  <= 16'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         w_held_ff <= 1'b0;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_ff <= 1'b0;
      end
   end

   always_comb begin
      wr_go    = aw_held_ff && w_held_ff && !bvalid_ff;
      wr_ctrl  = wr_go && addr_hit(awaddr_ff, psc_pkg::ADDR_CTRL);
      wr_cfg   = wr_go && addr_hit(awaddr_ff, psc_pkg::ADDR_CFG);
      // Data words are read-only but mapped, so writes there are accepted and dropped
      wr_hit   = wr_ctrl || wr_cfg || addr_hit(awaddr_ff, psc_pkg::ADDR_DLO)
                 || addr_hit(awaddr_ff, psc_pkg::ADDR_DHI);
      nxt_ctrl = merge16(ctrl_ff, wdata_ff, wstrb_ff);
      nxt_cfg  = merge16(cfg_ff, wdata_ff, wstrb_ff);
      // Offset, read bit and table code all come in the one write
      trig     = wr_ctrl && nxt_ctrl[psc_pkg::CTRL_RD_BIT]
                 && (nxt_ctrl[psc_pkg::CTRL_TBL_MSB:psc_pkg::CTRL_TBL_LSB]
                     == psc_pkg::TBL_STATS); // [RULE_05] [RULE_08]
      sel      = nxt_ctrl[psc_pkg::CTRL_OFS_MSB:psc_pkg::CTRL_OFS_LSB]; // [RULE_06]
      sel_ok   = (sel[9:5] == 5'h00); // [RULE_04]
      sel_idx  = sel[4:0];
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= psc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? psc_pkg::RESP_OKAY : psc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_ff <= psc_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= nxt_ctrl; // [RULE_06]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_ff <= psc_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Snapshot holds the counter as it stood before the clear; offsets past the
   // table give a word with valid low so that the host retries
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         snap_ff <= psc_pkg::SNAP_RST; // [RULE_02]
      end else if (trig) begin
         if (sel_ok) begin
            snap_ff <= {ovf_ff[sel_idx], 1'b1, cnt_ff[sel_idx]}; // [RULE_02]
         end else begin
            snap_ff <= psc_pkg::SNAP_RST; // [RULE_04]
         end
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = psc_pkg::RESP_OKAY;
      if (addr_hit(s_axi_araddr, psc_pkg::ADDR_CTRL)) begin
         nxt_rdata = {16'h0000, ctrl_ff};
      end else if (addr_hit(s_axi_araddr, psc_pkg::ADDR_DLO)) begin
         nxt_rdata = {16'h0000, snap_ff[15:0]}; // [RULE_07]
      end else if (addr_hit(s_axi_araddr, psc_pkg::ADDR_DHI)) begin
         nxt_rdata = {16'h0000, snap_ff[31:16]}; // [RULE_07]
      end else if (addr_hit(s_axi_araddr, psc_pkg::ADDR_CFG)) begin
         nxt_rdata = {16'h0000, cfg_ff};
      end else begin
         nxt_rresp = psc_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= psc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Receive frame classes
   always_comb begin
      len_max = cfg_ff[psc_pkg::CFG_LONG_BIT] ? psc_pkg::LEN_LONG_MAX : psc_pkg::LEN_STD_MAX;
      rl      = rx_evt.len;
      r_lo    = (rl < psc_pkg::LEN_MIN);
      r_hi    = (rl > len_max);
      r_mid   = !r_lo && !r_hi;
      r_err   = !rx_evt.crc_ok || rx_evt.sym_err || rx_evt.dribble;
      r_good  = rx_evt.done && r_mid && !r_err;
   end

   always_comb begin
      for (int i = 0; i < psc_pkg::CNT_NUM; i++) begin
         inc[i] = 14'h0000;
      end
      if (rx_evt.done) begin
         inc[psc_pkg::C_RX_OCT]      = rl; // [RULE_12]
         inc[psc_pkg::C_RX_SHORT]    = one(r_lo && !r_err); // [RULE_14]
         inc[psc_pkg::C_RX_BROKEN]   = one(r_lo && r_err); // [RULE_14]
         inc[psc_pkg::C_RX_LONG]     = one(r_hi && !r_err); // [RULE_14]
         inc[psc_pkg::C_RX_LONG_ERR] = one(r_hi && r_err); // [RULE_14]
         inc[psc_pkg::C_RX_SYM]      = one(r_mid && rx_evt.sym_err); // [RULE_15]
         inc[psc_pkg::C_RX_CRC]      = one(r_mid && !rx_evt.crc_ok && !rx_evt.sym_err
                                           && !rx_evt.dribble); // [RULE_15]
         inc[psc_pkg::C_RX_ALIGN]    = one(r_mid && !rx_evt.crc_ok && !rx_evt.sym_err
                                           && rx_evt.dribble); // [RULE_15]
         inc[psc_pkg::C_RX_CTRL]     = one(rx_evt.ctrl_type); // [RULE_16]
         inc[psc_pkg::C_RX_PAUSE]    = one(rx_evt.ctrl_type && rx_evt.pause_da
                                           && rx_evt.pause_op && !r_lo
                                           && rx_evt.crc_ok); // [RULE_16]
         inc[psc_pkg::C_RX_BC]       = one(r_good && rx_evt.bcast); // [RULE_17]
         inc[psc_pkg::C_RX_MC]       = one(r_good && rx_evt.mcast
                                           && !rx_evt.ctrl_type); // [RULE_17]
         inc[psc_pkg::C_RX_UC]       = one(r_good && !rx_evt.bcast
                                           && !rx_evt.mcast); // [RULE_17]
         inc[psc_pkg::C_RX_64]       = one(rl == psc_pkg::LEN_MIN); // [RULE_18]
         inc[psc_pkg::C_RX_127]      = one(rl > psc_pkg::LEN_MIN
                                           && rl <= psc_pkg::LEN_B1_MAX); // [RULE_18]
         inc[psc_pkg::C_RX_255]      = one(rl > psc_pkg::LEN_B1_MAX
                                           && rl <= psc_pkg::LEN_B2_MAX); // [RULE_18]
         inc[psc_pkg::C_RX_511]      = one(rl > psc_pkg::LEN_B2_MAX
                                           && rl <= psc_pkg::LEN_B3_MAX); // [RULE_18]
         inc[psc_pkg::C_RX_1023]     = one(rl > psc_pkg::LEN_B3_MAX
                                           && rl <= psc_pkg::LEN_B4_MAX); // [RULE_18]
         inc[psc_pkg::C_RX_MAX]      = one(rl > psc_pkg::LEN_B4_MAX && !r_hi); // [RULE_18]
      end
      if (tx_evt.done) begin
         inc[psc_pkg::C_TX_OCT]      = tx_evt.good ? tx_evt.len : 14'h0000; // [RULE_12]
         inc[psc_pkg::C_TX_PAUSE]    = one(tx_evt.pause); // [RULE_20]
         inc[psc_pkg::C_TX_BC]       = one(tx_evt.good && tx_evt.bcast); // [RULE_20]
         inc[psc_pkg::C_TX_MC]       = one(tx_evt.good && tx_evt.mcast); // [RULE_20]
         inc[psc_pkg::C_TX_UC]       = one(tx_evt.good && !tx_evt.bcast
                                           && !tx_evt.mcast); // [RULE_20]
         inc[psc_pkg::C_TX_DEFER]    = one(tx_evt.deferred); // [RULE_21]
         inc[psc_pkg::C_TX_ABANDON]  = one(tx_evt.abandoned); // [RULE_21]
         inc[psc_pkg::C_TX_ONE]      = one(tx_evt.good
                                           && tx_evt.coll_cnt == 5'h01); // [RULE_22]
         inc[psc_pkg::C_TX_MANY]     = one(tx_evt.good
                                           && tx_evt.coll_cnt > 5'h01); // [RULE_22]
      end
      // Collision pulses arrive during the frame, not with its end
      inc[psc_pkg::C_TX_LATE] = one(tx_evt.late_coll); // [RULE_19]
      inc[psc_pkg::C_TX_COLL] = one(tx_evt.collision); // [RULE_21]
      // Reserved slots never count
      inc[psc_pkg::C_RSV_1]   = 14'h0000; // [RULE_13]
      inc[psc_pkg::C_RSV_21]  = 14'h0000; // [RULE_13]
   end

   always_comb begin
      for (int i = 0; i < psc_pkg::CNT_NUM; i++) begin
         sum[i]     = {1'b0, cnt_ff[i]} + {17'h00000, inc[i]};
         clr_vec[i] = trig && sel_ok && (sel_idx == i[4:0]); // [RULE_10]
      end
   end

   // An event in the clearing cycle is kept as the first count after the read,
   // so no event is lost to the read-clear
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < psc_pkg::CNT_NUM; i++) begin
         if (rst) begin
            cnt_ff[i] <= 30'h0000_0000; // [RULE_01] [RULE_02]
            ovf_ff[i] <= 1'b0;
         end else if (clr_vec[i]) begin
            cnt_ff[i] <= {16'h0000, inc[i]}; // [RULE_10]
            ovf_ff[i] <= 1'b0; // [RULE_10]
         end else begin
            cnt_ff[i] <= sum[i][29:0];
            ovf_ff[i] <= ovf_ff[i] || sum[i][30]; // [RULE_23]
         end
      end
   end

endmodule : psc_stats

// File: verification/psc_stats_sva.sv
`timescale 1ns/1ps
module psc_stats_sva (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic ar_hs;
   logic ar_map;
   assign ar_hs  = s_axi_arvalid & s_axi_arready;
   assign ar_map = (s_axi_araddr[15:2] == psc_pkg::IDX_CTRL[13:0]) ||
                   (s_axi_araddr[15:2] == psc_pkg::IDX_DLO[13:0]) ||
                   (s_axi_araddr[15:2] == psc_pkg::IDX_DHI[13:0]) ||
                   (s_axi_araddr[15:2] == psc_pkg::IDX_CFG[13:0]);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel open while response pending");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open while data pending");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed before taken");
   r_answer_a: assert property (ar_hs |=> s_axi_rvalid)
      else $error("read data late");
   b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after handshake");
   rd_unmap_a: assert property (ar_hs && !ar_map |=>
      s_axi_rresp == psc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   rd_map_a: assert property (ar_hs && ar_map |=>
      s_axi_rresp == psc_pkg::RESP_OKAY && s_axi_rdata[31:16] == 16'h0)
      else $error("mapped read wrong response or upper half");
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
endmodule : psc_stats_sva

bind psc_stats psc_stats_sva u_sva (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// File: verification/port_statistics_counters_tb_top.sv
`timescale 1ns/1ps
module port_statistics_counters_tb_top;
   logic                 ref_clk = 1'b0;
   logic                 rst     = 1'b1;
   logic [15:0]          awaddr  = 16'h0;
   logic [15:0]          araddr  = 16'h0;
   logic [31:0]          wdata   = 32'h0;
   logic                 awvalid = 1'b0;
   logic                 wvalid  = 1'b0;
   logic                 bready  = 1'b0;
   logic                 arvalid = 1'b0;
   logic                 rready  = 1'b0;
   logic                 awready;
   logic                 wready;
   logic                 bvalid;
   logic                 arready;
   logic                 rvalid;
   logic [1:0]           bresp;
   logic [1:0]           rresp;
   logic [31:0]          rdata;
   psc_pkg::psc_rx_evt_t rx_evt  = '0;
   psc_pkg::psc_tx_evt_t tx_evt  = '0;
   int                   failures    = 0;
   int                   checks_done = 0;

   always #2 ref_clk = ~ref_clk;

   psc_stats u_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_evt(rx_evt), .tx_evt(tx_evt));

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Handshakes are sampled at the falling edge, where combinational readies have settled
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      logic       ah, wh, bh, bv;
      logic [1:0] r;
      int         n;
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      n = 0;
      do begin
         @(negedge ref_clk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid & bready;
         bv = bvalid;
         r  = bresp;
         @(posedge ref_clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         bready <= bv & !bh;
         n++;
      end while (!bh && n < 50);
      chk({31'h0, bh}, 32'h1);
      chk({30'h0, r}, {30'h0, er});
   endtask : axi_wr

   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh, rv;
      int   n;
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin
         @(negedge ref_clk);
         ah = arvalid & arready;
         rh = rvalid & rready;
         rv = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge ref_clk);
         if (ah) arvalid <= 1'b0;
         rready <= rv & !rh;
         n++;
      end while (!rh && n < 50);
      chk({31'h0, rh}, 32'h1);
   endtask : axi_rd

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask : rd_chk

   // Trigger, then upper word first with bounded retry while not valid, then lower word
   task automatic rd_cnt(input logic [4:0] o, output logic [31:0] w);
      logic [31:0] hi, lo;
      logic [1:0]  r;
      int          n;
      axi_wr(psc_pkg::ADDR_CTRL, {19'h0, 1'b1, 2'h3, 5'h0, o}, psc_pkg::RESP_OKAY);
      n = 0;
      do begin
         axi_rd(psc_pkg::ADDR_DHI, hi, r);
         n++;
      end while (hi[14] !== 1'b1 && n < 4);
      axi_rd(psc_pkg::ADDR_DLO, lo, r);
      w = {hi[15:0], lo[15:0]};
   endtask : rd_cnt

   // Clears the target first so leftovers of earlier frames cannot mask the expectation;
   // ek: 0 no count, 1 one count, 2 count equals the frame length
   task automatic ev(input logic t, input logic [4:0] o, input logic [1:0] ek,
                     input logic [13:0] len, input logic [12:0] fl);
      logic [31:0] w;
      rd_cnt(o, w);
      @(posedge ref_clk);
      if (t) tx_evt <= {1'b1, len, fl};
      else rx_evt <= {1'b1, len, fl[7:0]};
      @(posedge ref_clk);
      tx_evt <= '0;
      rx_evt <= '0;
      rd_cnt(o, w);
      chk(w, {2'b01, (ek == 2'h2) ? {16'h0, len} : {29'h0, ek[0]}});
   endtask : ev

   initial begin
      repeat (90000) @(posedge ref_clk);
      $display("BAD %0t watchdog expired", $time);
      failures++;
      give_verdict();
   end

   initial begin
      logic [31:0] w;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(psc_pkg::ADDR_CTRL, {16'h0, psc_pkg::CTRL_RST}, psc_pkg::RESP_OKAY);
      rd_chk(psc_pkg::ADDR_CFG, {16'h0, psc_pkg::CFG_RST}, psc_pkg::RESP_OKAY);
      rd_chk(psc_pkg::ADDR_DHI, 32'h0, psc_pkg::RESP_OKAY);
      rd_chk(16'h0010, 32'h0, psc_pkg::RESP_SLVERR);
      axi_wr(16'h0010, 32'h1c0e, psc_pkg::RESP_SLVERR);
      axi_wr(psc_pkg::ADDR_DLO, 32'hffff, psc_pkg::RESP_OKAY);
      axi_wr(psc_pkg::ADDR_CTRL, 32'h1c0e, psc_pkg::RESP_OKAY);
      rd_chk(psc_pkg::ADDR_CTRL, 32'h1c0e, psc_pkg::RESP_OKAY);
      rd_chk(psc_pkg::ADDR_DHI, 32'h4000, psc_pkg::RESP_OKAY);
      rd_chk(psc_pkg::ADDR_DLO, 32'h0, psc_pkg::RESP_OKAY);
      rd_cnt(5'h01, w);
      chk(w, 32'h4000_0000);
      rd_cnt(5'h15, w);
      chk(w, 32'h4000_0000);
      ev(1'b0, 5'h00, 2'h2, 14'h0064, 13'h0080);
      ev(1'b0, 5'h02, 2'h1, 14'h0028, 13'h0080);
      ev(1'b0, 5'h03, 2'h1, 14'h0028, 13'h0000);
      ev(1'b0, 5'h04, 2'h1, 14'h05f3, 13'h0080);
      ev(1'b0, 5'h05, 2'h1, 14'h05f3, 13'h0000);
      ev(1'b0, 5'h06, 2'h1, 14'h0064, 13'h00c0);
      ev(1'b0, 5'h07, 2'h1, 14'h0064, 13'h0000);
      ev(1'b0, 5'h08, 2'h1, 14'h0064, 13'h0020);
      ev(1'b0, 5'h09, 2'h1, 14'h0040, 13'h0084);
      ev(1'b0, 5'h0a, 2'h1, 14'h0040, 13'h0087);
      ev(1'b0, 5'h0b, 2'h1, 14'h0064, 13'h0090);
      ev(1'b0, 5'h0b, 2'h0, 14'h0064, 13'h0010);
      ev(1'b0, 5'h0c, 2'h1, 14'h0064, 13'h0088);
      ev(1'b0, 5'h0d, 2'h1, 14'h0064, 13'h0080);
      ev(1'b0, 5'h0e, 2'h1, 14'h0040, 13'h0000);
      ev(1'b0, 5'h0f, 2'h1, 14'h0041, 13'h0080);
      ev(1'b0, 5'h11, 2'h1, 14'h0100, 13'h0000);
      ev(1'b0, 5'h12, 2'h1, 14'h03ff, 13'h0080);
      ev(1'b0, 5'h13, 2'h1, 14'h05f2, 13'h0080);
      ev(1'b1, 5'h14, 2'h2, 14'h00c8, 13'h1000);
      ev(1'b1, 5'h16, 2'h1, 14'h0064, 13'h0001);
      ev(1'b1, 5'h17, 2'h1, 14'h0040, 13'h0800);
      ev(1'b1, 5'h18, 2'h1, 14'h0064, 13'h1400);
      ev(1'b1, 5'h19, 2'h1, 14'h0064, 13'h1200);
      ev(1'b1, 5'h1a, 2'h1, 14'h0064, 13'h1000);
      ev(1'b1, 5'h1a, 2'h0, 14'h0064, 13'h0000);
      ev(1'b1, 5'h1b, 2'h1, 14'h0064, 13'h1100);
      ev(1'b1, 5'h1c, 2'h1, 14'h0064, 13'h0002);
      ev(1'b1, 5'h1d, 2'h1, 14'h0064, 13'h0004);
      ev(1'b1, 5'h1e, 2'h1, 14'h0064, 13'h1008);
      ev(1'b1, 5'h1f, 2'h1, 14'h0064, 13'h1010);
      // Longer size limit moves 1536 octets from oversize into the top bin
      axi_wr(psc_pkg::ADDR_CFG, 32'h1, psc_pkg::RESP_OKAY);
      rd_chk(psc_pkg::ADDR_CFG, 32'h1, psc_pkg::RESP_OKAY);
      ev(1'b0, 5'h13, 2'h1, 14'h0600, 13'h0080);
      ev(1'b0, 5'h04, 2'h1, 14'h0601, 13'h0080);
      // Back-to-back maximum-length frames carry the octet count past its 30-bit range
      rd_cnt(5'h00, w);
      @(posedge ref_clk);
      rx_evt <= {1'b1, 14'h3fff, 8'h80};
      repeat (65541) @(posedge ref_clk);
      rx_evt <= '0;
      rd_cnt(5'h00, w);
      chk(w, 32'hc000_3ffb);
      rd_cnt(5'h00, w);
      chk(w, 32'h4000_0000);
      give_verdict();
   end
endmodule : port_statistics_counters_tb_top
